/* File: hdl/bsio_io_window.sv */
// I/O forwarding window compare
`timescale 1ns/1ps
`include "bsio_regs.svh"
module bsio_io_window (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Window bounds
  input wire logic [3:0] baseNib,
  input wire logic [3:0] limitNib,
  input wire logic [15:0] baseUpper,
  input wire logic [15:0] limitUpper,
  // Address to test
  input wire logic [31:0] ioAddr,
  input wire logic ioAddrValid,
  // Result
  output logic ioFwdValid,
  output logic ioFwdHit
);

  logic [31:0] lowBound;
  logic [31:0] highBound;

  // Bottom low bits zero, top low bits all ones
  assign lowBound = {baseUpper, baseNib, 12'h000};
  assign highBound = {limitUpper, limitNib, `BSIO_IO_LOW_FILL};

  // Forwarding decision
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ioFwdValid <= 1'b0;
      ioFwdHit <= 1'b0;
    end else begin
      ioFwdValid <= ioAddrValid;
      ioFwdHit <= ioAddrValid && (ioAddr >= lowBound) && (ioAddr <= highBound);
    end
  end

endmodule : bsio_io_window

/* File: hdl/bsio_lat_timer.sv */
// Secondary master latency timer
`timescale 1ns/1ps
module bsio_lat_timer #(
  parameter int LAT_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Setting
  input wire logic [LAT_W-1:0] latency,
  // Master cycle status
  input wire logic mstActive,
  input wire logic frameStart,
  input wire logic downstreamGrantN,
  input wire logic firstDataDone,
  input wire logic mwiCycle,
  // Results
  output logic latExpired,
  output logic latEndRequest
);
  import bsio_pkg::*;

  bsio_lat_state_t state_reg;
  logic [LAT_W-1:0] count_reg;
  logic zeroLat_reg;

  // Counts clocks from frame assertion
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= BSIO_LAT_IDLE;
      count_reg <= '0;
      zeroLat_reg <= 1'b0;
    end else if (!mstActive) begin
      state_reg <= BSIO_LAT_IDLE;
    end else begin
      case (state_reg)
        BSIO_LAT_IDLE: begin
          if (frameStart) begin
            count_reg <= latency;
            zeroLat_reg <= (latency == '0);
            state_reg <= (latency == '0) ? BSIO_LAT_EXPIRED : BSIO_LAT_COUNT;
          end
        end
        BSIO_LAT_COUNT: begin
          count_reg <= count_reg - 1'b1;
          if (count_reg == LAT_W'(1)) begin
            state_reg <= BSIO_LAT_EXPIRED;
          end
        end
        default: begin
          state_reg <= BSIO_LAT_EXPIRED;
        end
      endcase
    end
  end

  // Zero setting ends after first data once grant is gone, not for MWI
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      latExpired <= 1'b0;
      latEndRequest <= 1'b0;
    end else begin
      latExpired <= mstActive && (state_reg == BSIO_LAT_EXPIRED);
      latEndRequest <= mstActive && (state_reg == BSIO_LAT_EXPIRED) && downstreamGrantN
        && firstDataDone && !(mwiCycle && zeroLat_reg);
    end
  end

endmodule : bsio_lat_timer

/* File: hdl/bsio_regbank.sv */
// Secondary latency, I/O window and secondary status registers
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// - Latency timer counts clocks from frame assertion as master; resets zero.
// - Zero latency: end after first data once grant removed, except MWI.
// - I/O base and limit low nibbles read-only one: 32-bit I/O.
// - Limit bits 15:12 give window top bits 15:12; low bits ones.
// - Bounds, with separate upper halves, decide I/O forwarding.
// - Status bit 21 read-only one: 66 MHz capable.
// - Status bit 23 read-only one: fast back-to-back capable.
// - Bit 24 sets on parity error pin while command bit 6 set.
// - Bits 26:25 read-only select timing, medium 01.
// - Bit 27 sets when bridge as target signals target abort.
// - Bit 28 sets when bridge master receives target abort.
// - Bit 29 sets when bridge master receives master abort.
// - Bit 30 sets when system error pin asserted.
// - Bit 31 sets on detected address or data parity error.
`include "bsio_regs.svh"
module bsio_regbank #(
  parameter int LAT_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,

  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,

  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,

  // AXI4-Lite write response
  output bsio_pkg::bsio_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,

  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output bsio_pkg::bsio_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,

  // Secondary bus pins
  input wire logic downstreamParityErrN,
  input wire logic downstreamSystemErrN,

  // Secondary bus events
  input wire logic tgtAbortSignaled,
  input wire logic rcvdTgtAbort,
  input wire logic rcvdMstAbort,
  input wire logic parityErrDetected,

  // Secondary master cycle status
  input wire logic mstActive,
  input wire logic frameStart,
  input wire logic downstreamGrantN,
  input wire logic firstDataDone,
  input wire logic mwiCycle,

  // Latency results
  output logic latExpired,
  output logic latEndRequest,

  // I/O decode request
  input wire logic [31:0] ioAddr,
  input wire logic ioAddrValid,

  // I/O decode result
  output logic ioFwdValid,
  output logic ioFwdHit
);
  import bsio_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************

  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] off);
    regHit = (addr[7:2] == off[7:2]);
  endfunction : regHit

  function automatic logic [31:0] laneMask(input logic [3:0] strb);
    laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : laneMask

  function automatic logic mapped(input logic [7:0] addr);
    mapped = regHit(addr, `BSIO_OFF_CMD) || regHit(addr, `BSIO_OFF_LAT)
      || regHit(addr, `BSIO_OFF_IOSTS) || regHit(addr, `BSIO_OFF_IOUP);
  endfunction : mapped

  // ****************************************
  // Storage
  // ****************************************

  logic [31:0] cmd_reg;
  logic [LAT_W-1:0] lat_reg;
  logic [31:0] ioRw_reg;
  logic [31:0] sts_reg;
  logic [31:0] sts_next;
  logic [31:0] ioUp_reg;

  logic [7:0] wAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic [31:0] wMask;
  logic [31:0] setVec;
  logic [31:0] ioStsWord;
  logic [31:0] readWord;
  logic wrCmd;
  logic wrLat;
  logic wrIo;
  logic wrUp;

  // ****************************************
  // Write channel
  // ****************************************

  // Address and data taken in either order; write once both held
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wMask = doWrite ? laneMask(wStrb_reg) : 32'h0000_0000;

  // Per-register strobes, live only in the one write cycle
  assign wrCmd = doWrite && regHit(wAddr_reg, `BSIO_OFF_CMD);
  assign wrLat = doWrite && regHit(wAddr_reg, `BSIO_OFF_LAT);
  assign wrIo = doWrite && regHit(wAddr_reg, `BSIO_OFF_IOSTS);
  assign wrUp = doWrite && regHit(wAddr_reg, `BSIO_OFF_IOUP);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      wAddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wAddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_wready <= 1'b1;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Refused unless the address names a register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bresp <= BSIO_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bresp <= mapped(wAddr_reg) ? BSIO_RESP_OKAY : BSIO_RESP_SLVERR;
    end
  end

  // ****************************************
  // Writable fields
  // ****************************************

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg <= 32'h0000_0000;
    end else if (wrCmd) begin
      cmd_reg <= (cmd_reg & ~(wMask & `BSIO_CMD_RW_MASK))
        | (wData_reg & wMask & `BSIO_CMD_RW_MASK);
    end
  end

  // Latency setting; reset zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lat_reg <= LAT_W'(`BSIO_LAT_RST);
    end else if (wrLat && wMask[`BSIO_LAT_LSB]) begin
      lat_reg <= wData_reg[`BSIO_LAT_LSB +: LAT_W];
    end
  end

  // Only the window nibbles take writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ioRw_reg <= 32'h0000_0000;
    end else if (wrIo) begin
      ioRw_reg <= (ioRw_reg & ~(wMask & `BSIO_IOSTS_RW_MASK))
        | (wData_reg & wMask & `BSIO_IOSTS_RW_MASK);
    end
  end

  // Upper halves of both bounds
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ioUp_reg <= `BSIO_IOUP_RST;
    end else if (wrUp) begin
      ioUp_reg <= (ioUp_reg & ~wMask) | (wData_reg & wMask);
    end
  end

  // ****************************************
  // Sticky status
  // ****************************************

  always_comb begin
    setVec = 32'h0000_0000;
    setVec[`BSIO_STS_PERR_BIT] = !downstreamParityErrN && cmd_reg[`BSIO_CMD_PERR_BIT];
    setVec[`BSIO_STS_SIGTA_BIT] = tgtAbortSignaled;
    setVec[`BSIO_STS_RCVTA_BIT] = rcvdTgtAbort;
    setVec[`BSIO_STS_RCVMA_BIT] = rcvdMstAbort;
    setVec[`BSIO_STS_SERR_BIT] = !downstreamSystemErrN;
    setVec[`BSIO_STS_DPE_BIT] = parityErrDetected;
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    sts_next = sts_reg;
    if (wrIo) begin
      sts_next = sts_reg & ~(wData_reg & wMask);
    end
    sts_next = (sts_next | setVec) & `BSIO_IOSTS_W1C_MASK;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sts_reg <= 32'h0000_0000;
    end else begin
      sts_reg <= sts_next;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************

  // Constant fields: 32-bit I/O, 66 MHz, fast back-to-back, medium select
  assign ioStsWord = `BSIO_IOSTS_RO_VAL | ioRw_reg | sts_reg;

  always_comb begin
    readWord = 32'h0000_0000;
    if (regHit(s_axi_araddr, `BSIO_OFF_CMD)) begin
      readWord = cmd_reg & `BSIO_CMD_RW_MASK;
    end else if (regHit(s_axi_araddr, `BSIO_OFF_LAT)) begin
      readWord[`BSIO_LAT_LSB +: LAT_W] = lat_reg;
    end else if (regHit(s_axi_araddr, `BSIO_OFF_IOSTS)) begin
      readWord = ioStsWord;
    end else if (regHit(s_axi_araddr, `BSIO_OFF_IOUP)) begin
      readWord = ioUp_reg;
    end
  end

  // Address ready again only after the data handshake
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Data and code captured at the take, held until accepted
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BSIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= readWord;
      s_axi_rresp <= mapped(s_axi_araddr) ? BSIO_RESP_OKAY : BSIO_RESP_SLVERR;
    end
  end

  // ****************************************
  // Consumers
  // ****************************************

  // Secondary master latency
  bsio_lat_timer #(
    .LAT_W(LAT_W)
  ) u_lat (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .latency(lat_reg),
    .mstActive(mstActive),
    .frameStart(frameStart),
    .downstreamGrantN(downstreamGrantN),
    .firstDataDone(firstDataDone),
    .mwiCycle(mwiCycle),
    .latExpired(latExpired),
    .latEndRequest(latEndRequest)
  );

  // I/O forwarding decode
  bsio_io_window u_iowin (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .baseNib(ioRw_reg[`BSIO_IOBASE_LSB +: 4]),
    .limitNib(ioRw_reg[`BSIO_IOLIM_LSB +: 4]),
    .baseUpper(ioUp_reg[15:0]),
    .limitUpper(ioUp_reg[31:16]),
    .ioAddr(ioAddr),
    .ioAddrValid(ioAddrValid),
    .ioFwdValid(ioFwdValid),
    .ioFwdHit(ioFwdHit)
  );

endmodule : bsio_regbank

/* File: inc/bsio_pkg.sv */
// Types shared by the bridge secondary register block
package bsio_pkg;

  typedef enum logic [1:0] {
    BSIO_RESP_OKAY = 2'h0,
    BSIO_RESP_SLVERR = 2'h2
  } bsio_resp_t;

  // Gray order along idle, counting, expired
  typedef enum logic [1:0] {
    BSIO_LAT_IDLE = 2'h0,
    BSIO_LAT_COUNT = 2'h1,
    BSIO_LAT_EXPIRED = 2'h3
  } bsio_lat_state_t;

endpackage : bsio_pkg

/* File: inc/bsio_regs.svh */
// Register offsets, field positions and reset values of the bridge block
`ifndef BSIO_REGS_SVH
`define BSIO_REGS_SVH

// Byte offsets
`define BSIO_OFF_CMD 8'h04
`define BSIO_OFF_LAT 8'h18
`define BSIO_OFF_IOSTS 8'h1C
`define BSIO_OFF_IOUP 8'h30

// Field positions
`define BSIO_CMD_PERR_BIT 6
`define BSIO_LAT_LSB 24
`define BSIO_IOBASE_LSB 4
`define BSIO_IOLIM_LSB 12
`define BSIO_STS_PERR_BIT 24
`define BSIO_STS_SIGTA_BIT 27
`define BSIO_STS_RCVTA_BIT 28
`define BSIO_STS_RCVMA_BIT 29
`define BSIO_STS_SERR_BIT 30
`define BSIO_STS_DPE_BIT 31

// Masks and reset values
`define BSIO_LAT_RST 8'h00
`define BSIO_CMD_RW_MASK 32'h0000_0040
`define BSIO_IOSTS_RW_MASK 32'h0000_F0F0
`define BSIO_IOSTS_W1C_MASK 32'hF900_0000
`define BSIO_IOSTS_RO_VAL 32'h02A0_0101
`define BSIO_IOUP_RST 32'h0000_0000
`define BSIO_IO_LOW_FILL 12'hFFF

`endif

/* File: tb/bsio_regbank_checker.sv */
// Assertion checker for the bridge secondary register block
`timescale 1ns/1ps
module bsio_regbank_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input bsio_pkg::bsio_resp_t s_axi_rresp,
  // Secondary side
  input wire logic mstActive,
  input wire logic downstreamGrantN,
  input wire logic firstDataDone,
  input wire logic latExpired,
  input wire logic latEndRequest,
  input wire logic ioAddrValid,
  input wire logic ioFwdValid
);
  import bsio_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  property p_wrResp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wrResp: assert property (p_wrResp) else $error("write answer late");
  property p_rdResp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rdResp: assert property (p_rdResp) else $error("read answer late");
  property p_errZero;
    s_axi_rvalid && s_axi_rresp == BSIO_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_errZero: assert property (p_errZero) else $error("refused read data");
  property p_fwdValid;
    ioAddrValid |=> ioFwdValid;
  endproperty
  a_fwdValid: assert property (p_fwdValid) else $error("no decode result");
  property p_fwdCause;
    ioFwdValid |-> $past(ioAddrValid);
  endproperty
  a_fwdCause: assert property (p_fwdCause) else $error("stray decode result");
  property p_expDrop;
    !mstActive |=> !latExpired;
  endproperty
  a_expDrop: assert property (p_expDrop) else $error("expiry outlives cycle");
  property p_expCause;
    $rose(latExpired) |-> $past(mstActive);
  endproperty
  a_expCause: assert property (p_expCause) else $error("expiry while idle");
  property p_endCause;
    latEndRequest |-> $past(downstreamGrantN && firstDataDone);
  endproperty
  a_endCause: assert property (p_endCause) else $error("early end request");
  c_slvErr: cover property (s_axi_rvalid && s_axi_rresp == BSIO_RESP_SLVERR);
  c_exp: cover property ($rose(latExpired));
  c_end: cover property ($rose(latEndRequest));
endmodule : bsio_regbank_checker

bind bsio_regbank bsio_regbank_checker chk (.clk_sys, .rst_b, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .mstActive,
  .downstreamGrantN, .firstDataDone, .latExpired, .latEndRequest, .ioAddrValid,
  .ioFwdValid);

/* File: tb/bsio_sec_agent.sv */
// Secondary bus agents: error pins, event pulses and master cycle status
`timescale 1ns/1ps
module bsio_sec_agent (
  // Clock
  input wire logic clk_sys,
  // Event pins and pulses
  output logic downstreamParityErrN,
  output logic downstreamSystemErrN,
  output logic tgtAbortSignaled,
  output logic rcvdTgtAbort,
  output logic rcvdMstAbort,
  output logic parityErrDetected,
  // Master cycle status
  output logic mstActive,
  output logic frameStart,
  output logic downstreamGrantN,
  output logic firstDataDone,
  output logic mwiCycle
);
  logic [5:0] ev = 6'h00;
  assign tgtAbortSignaled = ev[0];
  assign rcvdTgtAbort = ev[1];
  assign rcvdMstAbort = ev[2];
  // Pins rest high on their pull-ups
  assign downstreamSystemErrN = !ev[3];
  assign parityErrDetected = ev[4];
  assign downstreamParityErrN = !ev[5];
  initial begin
    {mstActive, frameStart, downstreamGrantN, firstDataDone, mwiCycle} = 5'h00;
  end
  // One clock of one event
  task automatic fire(input int k);
    @(posedge clk_sys);
    ev <= 6'h01 << k;
    @(posedge clk_sys);
    ev <= 6'h00;
  endtask : fire
  // Grant already gone and first data done, so the timer decides, with mwiCycle also blocking the end at zero latency
  task automatic begin_cycle(input logic mwi);
    @(posedge clk_sys);
    {mstActive, frameStart, downstreamGrantN, firstDataDone} <= 4'hF;
    mwiCycle <= mwi;
    @(posedge clk_sys);
    frameStart <= 1'b0;
  endtask : begin_cycle
  task automatic end_cycle;
    @(posedge clk_sys);
    {mstActive, downstreamGrantN, firstDataDone, mwiCycle} <= 4'h0;
  endtask : end_cycle
endmodule : bsio_sec_agent

/* File: tb/tb.sv */
// Self-checking testbench of the bridge secondary register block
`timescale 1ns/1ps
module tb;
  import bsio_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ioAddr;
  logic [3:0] s_axi_wstrb;
  bsio_resp_t s_axi_bresp, s_axi_rresp, bres;
  logic downstreamParityErrN, downstreamSystemErrN, tgtAbortSignaled, rcvdTgtAbort;
  logic rcvdMstAbort, parityErrDetected, mstActive, frameStart, downstreamGrantN;
  logic firstDataDone, mwiCycle, latExpired, latEndRequest, ioAddrValid, ioFwdValid;
  logic ioFwdHit;
  int failures = 0;
  int compares = 0;
  int evBit [5] = '{27, 28, 29, 30, 31};
  logic [31:0] ioA [5] = '{32'h3000, 32'h5FFF, 32'h2FFF, 32'h6000, 32'h1_3000};
  logic ioH [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  always #2.5 clk_sys = ~clk_sys;
  bsio_regbank dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .downstreamParityErrN,
    .downstreamSystemErrN, .tgtAbortSignaled, .rcvdTgtAbort, .rcvdMstAbort,
    .parityErrDetected, .mstActive, .frameStart, .downstreamGrantN, .firstDataDone,
    .mwiCycle, .latExpired, .latEndRequest, .ioAddr, .ioAddrValid, .ioFwdValid, .ioFwdHit);
  bsio_sec_agent agent (.clk_sys, .downstreamParityErrN, .downstreamSystemErrN,
    .tgtAbortSignaled, .rcvdTgtAbort, .rcvdMstAbort, .parityErrDetected, .mstActive,
    .frameStart, .downstreamGrantN, .firstDataDone, .mwiCycle);
  // ************************************
  // Helpers
  // ************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bres = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input bsio_resp_t er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask : rdc
  task automatic io(input logic [31:0] a, input logic h);
    @(posedge clk_sys);
    ioAddr <= a;
    ioAddrValid <= 1'b1;
    @(posedge clk_sys);
    ioAddrValid <= 1'b0;
    #1;
    chk({31'h0, ioFwdValid}, 32'h1);
    chk({31'h0, ioFwdHit}, {31'h0, h});
  endtask : io
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_reset;
    rdc(8'h1C, 32'h02A0_0101, BSIO_RESP_OKAY);
    rdc(8'h18, 32'h0, BSIO_RESP_OKAY);
    wr(8'h18, 32'h00FF_FFFF);
    chk({30'h0, bres}, {30'h0, BSIO_RESP_OKAY});
    rdc(8'h18, 32'h0, BSIO_RESP_OKAY);
    // Unstrobed top byte must leave the latency alone
    s_axi_wstrb <= 4'h7;
    wr(8'h18, 32'hFF00_0000);
    s_axi_wstrb <= 4'hF;
    rdc(8'h18, 32'h0, BSIO_RESP_OKAY);
    wr(8'h40, 32'hFFFF_FFFF);
    chk({30'h0, bres}, {30'h0, BSIO_RESP_SLVERR});
    rdc(8'h40, 32'h0, BSIO_RESP_SLVERR);
  endtask : t_reset
  task automatic t_window;
    wr(8'h1C, 32'hFFFF_FFFF);
    rdc(8'h1C, 32'h02A0_F1F1, BSIO_RESP_OKAY);
    wr(8'h1C, 32'h0000_5030);
    rdc(8'h1C, 32'h02A0_5131, BSIO_RESP_OKAY);
    for (int i = 0; i < 5; i++) io(ioA[i], ioH[i]);
    wr(8'h30, 32'h0001_0001);
    io(32'h1_3000, 1'b1);
    io(32'h1_5FFF, 1'b1);
    io(32'h3000, 1'b0);
  endtask : t_window
  task automatic t_events;
    for (int k = 0; k < 5; k++) begin
      agent.fire(k);
      rdc(8'h1C, 32'h02A0_5131 | (32'h1 << evBit[k]), BSIO_RESP_OKAY);
      wr(8'h1C, 32'h0000_5030);
      rdc(8'h1C, 32'h02A0_5131 | (32'h1 << evBit[k]), BSIO_RESP_OKAY);
      wr(8'h1C, 32'h0000_5030 | (32'h1 << evBit[k]));
      rdc(8'h1C, 32'h02A0_5131, BSIO_RESP_OKAY);
    end
    // Parity pin counts only with response enabled
    agent.fire(5);
    rdc(8'h1C, 32'h02A0_5131, BSIO_RESP_OKAY);
    wr(8'h04, 32'h0000_0040);
    agent.fire(5);
    rdc(8'h1C, 32'h03A0_5131, BSIO_RESP_OKAY);
    wr(8'h1C, 32'h0100_5030);
    rdc(8'h1C, 32'h02A0_5131, BSIO_RESP_OKAY);
  endtask : t_events
  task automatic t_latency;
    int n;
    wr(8'h18, 32'h0300_0000);
    rdc(8'h18, 32'h0300_0000, BSIO_RESP_OKAY);
    agent.begin_cycle(1'b0);
    for (n = 1; n < 20; n++) begin
      @(posedge clk_sys);
      #1;
      if (latExpired === 1'b1) break;
    end
    chk(n, 4);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, latEndRequest}, 32'h1);
    agent.end_cycle();
    repeat (2) @(posedge clk_sys);
    #1;
    chk({30'h0, latExpired, latEndRequest}, 32'h0);
    wr(8'h18, 32'h0);
    agent.begin_cycle(1'b1);
    repeat (6) @(posedge clk_sys);
    #1;
    chk({31'h0, latEndRequest}, 32'h0);
    agent.end_cycle();
    agent.begin_cycle(1'b0);
    repeat (6) @(posedge clk_sys);
    #1;
    chk({31'h0, latEndRequest}, 32'h1);
    agent.end_cycle();
  endtask : t_latency
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ioAddr} = 80'h0;
    s_axi_wstrb = 4'hF;
    ioAddrValid = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_window();
    t_events();
    t_latency();
    give_verdict();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule : tb
